// ===== src/kea_controller.sv
// Keyless entry receiver, alarm state machine and fault logger
// What this block does
// - Battery return restores mode: ready states to normal, armed, warning kept
// - Armed mode at battery return sounds horn and flashes as alarm
// - Unlock unused for 30 s relocks and arms
// - Panic command sounds the horn for about 27 seconds
// - Any remote command stops a sounding panic horn
// - Lock command locks the doors; arms only when no door is open
// - Unlock command unlocks doors and leaves armed mode
// - Unlock with lamp coupling lights front room lamp 30 s
// - Remote commands act only with ignition key removed
// - At most two paired codes, pairing only via tester
// - No command acts while code registration runs
// - Lock asserts output at once; doors closed arms, two flashes
// - Unlock drives the unlock relay for 0.5 seconds
// - Unlock flashes hazards once only when all locks read unlocked
// - Fault 10 when auto lock fails above 50 km/h, ignition on
// - Fault 05 or 06 when no knob follows lock or unlock relay
// - Faults 07, 08, 09 for switch locking with engine running
// - Fault 13 for speed over 3 km/h, ignition on, alternator low
// - Fault 15 history when speed exceeds 200 km/h
// - Fault 16 history on crash input with ignition off
// - Fault 22 history when washer switch active over 10 s
`timescale 1ns/10ps
module kea_controller
  import kea_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // Battery backed storage of the mode, restored after power return
  input wire logic BATT_RESTORE_I,
  input wire alarm_mode_t STORED_MODE_I,
  output alarm_mode_t MODE_O,
  // Radio receiver
  input wire rf_msg_t RF_MSG_I,
  // Diagnostic tester
  input wire logic TESTER_PAIR_I,
  input wire logic TESTER_SLOT_I,
  input wire logic TESTER_CLEAR_I,
  output logic PAIRING_O,
  // Vehicle inputs
  input wire logic IGNITION_SWITCH_I,
  input wire logic KEY_IN_I,
  input wire logic ENGINE_RUN_I,
  input wire logic ALTERNATOR_I,
  input wire logic [7:0] SPEED_I,
  input wire door_state_t DOORS_I,
  input wire logic ROOM_LAMP_COUPLE_I,
  input wire logic CENTRAL_SW_LOCK_I,
  input wire logic DRIVER_SW_LOCK_I,
  input wire logic PASS_SW_LOCK_I,
  input wire logic AUTO_LOCK_REQ_I,
  input wire logic CRASH_I,
  input wire logic WASHER_SW_I,
  // Actuators
  output logic LOCK_RELAY_O,
  output logic UNLOCK_RELAY_O,
  output logic HORN_O,
  output logic HAZARD_O,
  output logic ROOM_LAMP_O,
  // Fault log, bit n is fault code n
  output logic [FLT_W-1:0] FAULTS_O
);

  // =====================================================
  // Tick divider
  // =====================================================
  logic [31:0] div;
  logic tick;
  logic [3:0] beat;

  // Beat counts ticks so the warning cadence follows TICK_DIV
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      div <= '0;
      tick <= 1'b0;
      beat <= 4'h0;
    end else begin
      tick <= (div == TICK_DIV - 1);
      div <= (div == TICK_DIV - 1) ? '0 : div + 32'd1;
      if (tick) begin
        beat <= (beat == 4'(2 * FLASH_TICKS - 1)) ? 4'h0 : beat + 4'h1;
      end
    end
  end

  // =====================================================
  // Pairing and command filtering
  // =====================================================
  logic [CODE_W-1:0] key_code [KEY_SLOTS];
  logic [KEY_SLOTS-1:0] key_valid;
  logic known;
  logic cmd_ok;
  logic is_lock;
  logic is_unlock;
  logic is_panic;

  // Pairing latches the next received code into the chosen slot
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PAIRING_O <= 1'b0;
      key_valid <= '0;
      key_code[0] <= '0;
      key_code[1] <= '0;
    end else if (TESTER_PAIR_I && !PAIRING_O) begin
      PAIRING_O <= 1'b1;
      key_valid[TESTER_SLOT_I] <= 1'b0;
    end else if (PAIRING_O && RF_MSG_I.valid) begin
      key_code[TESTER_SLOT_I] <= RF_MSG_I.code;
      key_valid[TESTER_SLOT_I] <= 1'b1;
      PAIRING_O <= 1'b0;
    end
  end

  assign known = (key_valid[0] && key_code[0] == RF_MSG_I.code) ||
                 (key_valid[1] && key_code[1] == RF_MSG_I.code);
  assign cmd_ok = RF_MSG_I.valid && known && !PAIRING_O && !KEY_IN_I;
  assign is_lock = cmd_ok && RF_MSG_I.cmd == CMD_LOCK;
  assign is_unlock = cmd_ok && RF_MSG_I.cmd == CMD_UNLOCK;
  assign is_panic = cmd_ok && RF_MSG_I.cmd == CMD_PANIC;

  // =====================================================
  // Timers
  // =====================================================
  logic relock_start, relock_run, relock_done;
  logic panic_run, warn_run, warn_done, lamp_run;
  logic lpulse_start, lpulse_run, upulse_run;
  logic flash_run, flash_done, washer_done, knob_done, wash_run;
  logic warn_start;
  logic [2:0] flash_left;
  logic any_cmd;
  logic knob_start;

  assign any_cmd = cmd_ok && RF_MSG_I.cmd != CMD_NONE;

  kea_timer u_relock (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick),
    .start_i(relock_start),
    .stop_i(DOORS_I.any_open || KEY_IN_I || (any_cmd && !is_unlock)),
    .load_i(TW'(RELOCK_TICKS)), .run_o(relock_run),
    .done_o(relock_done));
  kea_timer u_panic (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick),
    .start_i(is_panic && !panic_run),
    .stop_i(any_cmd && panic_run),
    .load_i(TW'(PANIC_TICKS)), .run_o(panic_run), .done_o());
  kea_timer u_warn (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick),
    .start_i(warn_start), .stop_i(any_cmd),
    .load_i(TW'(WARN_TICKS)), .run_o(warn_run), .done_o(warn_done));
  kea_timer u_lamp (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick),
    .start_i(is_unlock && ROOM_LAMP_COUPLE_I), .stop_i(is_lock),
    .load_i(TW'(LAMP_TICKS)), .run_o(lamp_run), .done_o());
  kea_timer u_lpulse (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick),
    .start_i(lpulse_start), .stop_i(1'b0),
    .load_i(TW'(LOCK_TICKS)), .run_o(lpulse_run), .done_o());
  kea_timer u_upulse (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick),
    .start_i(is_unlock && !lpulse_start), .stop_i(lpulse_start),
    .load_i(TW'(UNLOCK_TICKS)), .run_o(upulse_run), .done_o());
  kea_timer u_flash (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick),
    .start_i(flash_left != 3'd0 && !flash_run && !flash_done),
    .stop_i(1'b0), .load_i(TW'(FLASH_TICKS)), .run_o(flash_run),
    .done_o(flash_done));
  kea_timer u_washer (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick),
    .start_i(WASHER_SW_I && !wash_run), .stop_i(!WASHER_SW_I),
    .load_i(TW'(WASHER_TICKS)), .run_o(wash_run), .done_o(washer_done));
  kea_timer u_knob (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick),
    .start_i(knob_start), .stop_i(1'b0),
    .load_i(TW'(KNOB_TICKS)), .run_o(), .done_o(knob_done));

  // =====================================================
  // Alarm mode machine
  // =====================================================
  logic restore_q;
  logic [1:0] arm_flash_req;
  logic unlock_check;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      MODE_O <= MODE_NORMAL;
      restore_q <= 1'b0;
      warn_start <= 1'b0;
      relock_start <= 1'b0;
      lpulse_start <= 1'b0;
      arm_flash_req <= 2'd0;
    end else begin
      restore_q <= BATT_RESTORE_I;
      warn_start <= 1'b0;
      relock_start <= 1'b0;
      lpulse_start <= 1'b0;
      arm_flash_req <= 2'd0;
      if (BATT_RESTORE_I && !restore_q) begin
        unique case (STORED_MODE_I)
          MODE_ARMED: begin
            MODE_O <= MODE_ARMED;
            warn_start <= 1'b1;
          end
          MODE_WARNING: begin
            MODE_O <= MODE_WARNING;
            warn_start <= 1'b1;
          end
          default: MODE_O <= MODE_NORMAL;
        endcase
      end else if (is_lock) begin
        lpulse_start <= 1'b1;
        if (!DOORS_I.any_open) begin
          MODE_O <= MODE_ARMED;
          arm_flash_req <= 2'd2;
        end else begin
          MODE_O <= MODE_ARMED_READY;
        end
      end else if (is_unlock) begin
        MODE_O <= MODE_RELOCK_READY;
        relock_start <= 1'b1;
      end else if (relock_done) begin
        lpulse_start <= 1'b1;
        MODE_O <= MODE_ARMED;
        arm_flash_req <= 2'd2;
      end else begin
        unique case (MODE_O)
          MODE_ARMED: begin
            if (ENGINE_RUN_I) begin
              MODE_O <= MODE_NORMAL;
            end else if (DOORS_I.any_open) begin
              MODE_O <= MODE_WARNING;
              warn_start <= 1'b1;
            end
          end
          MODE_WARNING: begin
            if (any_cmd) begin
              MODE_O <= MODE_NORMAL;
            end else if (warn_done) begin
              MODE_O <= MODE_WARN_DONE;
            end
          end
          MODE_ARMED_READY: begin
            if (KEY_IN_I || DOORS_I.all_unlocked) begin
              MODE_O <= MODE_NORMAL;
            end
          end
          MODE_RELOCK_READY: begin
            if (!relock_run && !relock_start) begin
              MODE_O <= MODE_NORMAL;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // =====================================================
  // Outputs: relays, horn, hazards, lamp
  // =====================================================
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      flash_left <= 3'd0;
      unlock_check <= 1'b0;
      LOCK_RELAY_O <= 1'b0;
      UNLOCK_RELAY_O <= 1'b0;
      HORN_O <= 1'b0;
      HAZARD_O <= 1'b0;
      ROOM_LAMP_O <= 1'b0;
    end else begin
      LOCK_RELAY_O <= lpulse_run || lpulse_start;
      UNLOCK_RELAY_O <= upulse_run;
      ROOM_LAMP_O <= lamp_run;
      // Warning: on for the first half of each one-second beat
      HORN_O <= panic_run || (warn_run && beat < 4'(FLASH_TICKS));
      HAZARD_O <= flash_run || (warn_run && beat < 4'(FLASH_TICKS));
      unlock_check <= is_unlock || (unlock_check && upulse_run);
      if (arm_flash_req != 2'd0) begin
        flash_left <= {1'b0, arm_flash_req};
      end else if (unlock_check && !upulse_run && DOORS_I.all_unlocked) begin
        flash_left <= 3'd1;
      end else if (flash_done && flash_left != 3'd0) begin
        flash_left <= flash_left - 3'd1;
      end
    end
  end

  // =====================================================
  // Fault log, kept until the tester clears it
  // =====================================================
  logic knob_lock, knob_unlock, knob_auto;
  logic [FLT_W-1:0] next_faults;

  assign knob_start = lpulse_start || (is_unlock && !lpulse_start) ||
                      AUTO_LOCK_REQ_I;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      knob_lock <= 1'b0;
      knob_unlock <= 1'b0;
      knob_auto <= 1'b0;
    end else if (knob_start) begin
      knob_lock <= lpulse_start;
      knob_unlock <= is_unlock && !lpulse_start;
      knob_auto <= AUTO_LOCK_REQ_I && IGNITION_SWITCH_I &&
                   SPEED_I > SPEED_AUTO_LOCK;
    end else if (knob_done) begin
      knob_lock <= 1'b0;
      knob_unlock <= 1'b0;
      knob_auto <= 1'b0;
    end
  end

  always_comb begin
    next_faults = '0;
    if (knob_done) begin
      next_faults[FLT_LOCK_OUT] = knob_lock && !DOORS_I.any_locked;
      next_faults[FLT_UNLOCK_OUT] = knob_unlock && DOORS_I.any_locked;
      next_faults[FLT_AUTO_LOCK] = knob_auto && DOORS_I.all_unlocked;
    end
    next_faults[FLT_CENTRAL_SW] = CENTRAL_SW_LOCK_I && ENGINE_RUN_I;
    next_faults[FLT_DRIVER_SW] = DRIVER_SW_LOCK_I && ENGINE_RUN_I;
    next_faults[FLT_PASS_SW] = PASS_SW_LOCK_I && ENGINE_RUN_I;
    next_faults[FLT_SPEED_SIG] = SPEED_I > SPEED_MOVING &&
                                 IGNITION_SWITCH_I && !ALTERNATOR_I;
    next_faults[FLT_SPEED_MAX] = SPEED_I > SPEED_MAX;
    next_faults[FLT_CRASH_IN] = CRASH_I && !IGNITION_SWITCH_I;
    next_faults[FLT_WASHER] = washer_done;
  end

  // A new fault in the clearing cycle still lands
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      FAULTS_O <= '0;
    end else if (TESTER_CLEAR_I) begin
      FAULTS_O <= next_faults;
    end else begin
      FAULTS_O <= FAULTS_O | next_faults;
    end
  end

endmodule : kea_controller

// ===== src/kea_pkg.sv
// Shared types, codes and timing counts of the keyless entry controller
package kea_pkg;

  // =====================================================
  // Clock and timing
  // =====================================================
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned RELOCK_MS = 30_000;
  localparam int unsigned LAMP_MS = 30_000;
  localparam int unsigned PANIC_MS = 27_000;
  localparam int unsigned WARN_MS = 27_000;
  localparam int unsigned UNLOCK_PULSE_MS = 500;
  localparam int unsigned LOCK_PULSE_MS = 500;
  localparam int unsigned FLASH_MS = 500;
  localparam int unsigned WASHER_MS = 10_000;
  localparam int unsigned KNOB_WAIT_MS = 1_000;
  localparam int unsigned RELOCK_TICKS = RELOCK_MS / TICK_MS;
  localparam int unsigned LAMP_TICKS = LAMP_MS / TICK_MS;
  localparam int unsigned PANIC_TICKS = PANIC_MS / TICK_MS;
  localparam int unsigned WARN_TICKS = WARN_MS / TICK_MS;
  localparam int unsigned UNLOCK_TICKS = UNLOCK_PULSE_MS / TICK_MS;
  localparam int unsigned LOCK_TICKS = LOCK_PULSE_MS / TICK_MS;
  localparam int unsigned FLASH_TICKS = FLASH_MS / TICK_MS;
  localparam int unsigned WASHER_TICKS = WASHER_MS / TICK_MS;
  localparam int unsigned KNOB_TICKS = KNOB_WAIT_MS / TICK_MS;
  localparam int TW = 9;

  // =====================================================
  // Speed thresholds, km/h
  // =====================================================
  localparam logic [7:0] SPEED_AUTO_LOCK = 8'd50;
  localparam logic [7:0] SPEED_MOVING = 8'd3;
  localparam logic [7:0] SPEED_MAX = 8'd200;

  // =====================================================
  // Fault log bit positions (fault code number)
  // =====================================================
  localparam int FLT_LOCK_OUT = 5;
  localparam int FLT_UNLOCK_OUT = 6;
  localparam int FLT_CENTRAL_SW = 7;
  localparam int FLT_DRIVER_SW = 8;
  localparam int FLT_PASS_SW = 9;
  localparam int FLT_AUTO_LOCK = 10;
  localparam int FLT_SPEED_SIG = 13;
  localparam int FLT_SPEED_MAX = 15;
  localparam int FLT_CRASH_IN = 16;
  localparam int FLT_WASHER = 22;
  localparam int FLT_W = 23;

  localparam int KEY_SLOTS = 2;
  localparam int CODE_W = 32;

  // =====================================================
  // Types
  // =====================================================
  typedef enum logic [1:0] {
    CMD_NONE, CMD_LOCK, CMD_UNLOCK, CMD_PANIC
  } rf_cmd_t;

  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_ARMED_READY, MODE_ARMED, MODE_WARNING,
    MODE_WARN_DONE, MODE_RELOCK_READY
  } alarm_mode_t;

  typedef struct packed {
    logic valid;
    logic [CODE_W-1:0] code;
    rf_cmd_t cmd;
  } rf_msg_t;

  typedef struct packed {
    logic any_open;
    logic any_locked;
    logic all_unlocked;
  } door_state_t;

endpackage : kea_pkg

// ===== src/kea_timer.sv
// Down-counting interval timer clocked by the slow tick enable
`timescale 1ns/10ps
module kea_timer
  import kea_pkg::*;
#(
  parameter int W = TW
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [W-1:0] load_i,
  // Status
  output logic run_o,
  output logic done_o
);

  logic [W-1:0] count;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        count <= load_i;
      end else if (stop_i) begin
        count <= '0;
      end else if (tick_i && count != '0) begin
        count <= count - 1'b1;
        done_o <= (count == W'(1));
      end
    end
  end

  assign run_o = (count != '0);

endmodule : kea_timer

// ===== verification/kea_remote_model.sv
// Remote key transmitter model: button press length to coded frame
`timescale 1ns/10ps
module kea_remote_model
  import kea_pkg::*;
#(
  parameter int unsigned T_MIN = 4,
  parameter int unsigned T_MID = 20,
  parameter int unsigned T_MAX = 40
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Buttons and own code
  input wire logic door_btn_i,
  input wire logic panic_btn_i,
  input wire logic [CODE_W-1:0] code_i,
  // Radio frame
  output rf_msg_t msg_o
);
  int unsigned held;
  logic was_panic;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      msg_o <= '0;
      held <= 0;
      was_panic <= 1'h0;
    end else begin
      // Idle air carries noise, never the last frame
      msg_o <= '{1'h0, ~msg_o.code, rf_cmd_t'(~msg_o.cmd)};
      was_panic <= panic_btn_i;
      if (door_btn_i || panic_btn_i) begin
        held <= held + 1;
      end else if (held != 0) begin
        held <= 0;
        if (was_panic && held >= T_MIN && held <= T_MID) begin
          msg_o <= '{1'h1, code_i, CMD_PANIC};
        end else if (!was_panic && held >= T_MIN && held < T_MID) begin
          msg_o <= '{1'h1, code_i, CMD_LOCK};
        end else if (!was_panic && held >= T_MID && held <= T_MAX) begin
          msg_o <= '{1'h1, code_i, CMD_UNLOCK};
        end
      end
    end
  end
endmodule : kea_remote_model

// ===== verification/kea_controller_properties.sv
// Port-level assertions of the keyless entry controller
`timescale 1ns/10ps
module kea_controller_properties
  import kea_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // Inputs
  input wire rf_msg_t RF_MSG_I,
  input wire logic TESTER_SLOT_I,
  input wire logic TESTER_CLEAR_I,
  input wire logic KEY_IN_I,
  input wire door_state_t DOORS_I,
  input wire logic ROOM_LAMP_COUPLE_I,
  // Outputs
  input wire logic PAIRING_O,
  input wire alarm_mode_t MODE_O,
  input wire logic LOCK_RELAY_O,
  input wire logic UNLOCK_RELAY_O,
  input wire logic HORN_O,
  input wire logic ROOM_LAMP_O,
  input wire logic [FLT_W-1:0] FAULTS_O
);
  logic [CODE_W-1:0] slot_code [KEY_SLOTS];
  logic [KEY_SLOTS-1:0] slot_ok;
  logic acc;
  int unsigned relay_len;
  // Mirror of paired codes, learnt from the pairing frames
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      slot_ok <= '0;
    end else if (PAIRING_O && RF_MSG_I.valid) begin
      slot_ok[TESTER_SLOT_I] <= 1'h1;
      slot_code[TESTER_SLOT_I] <= RF_MSG_I.code;
    end
  end
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      relay_len <= 0;
    end else begin
      relay_len <= UNLOCK_RELAY_O ? relay_len + 1 : 0;
    end
  end
  assign acc = RF_MSG_I.valid && !PAIRING_O && !KEY_IN_I &&
    ((slot_ok[0] && slot_code[0] == RF_MSG_I.code) ||
     (slot_ok[1] && slot_code[1] == RF_MSG_I.code));
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // =====================================================
  // Assertions
  // =====================================================
  a_lock_relay: assert property (acc && RF_MSG_I.cmd == CMD_LOCK
    |-> ##2 LOCK_RELAY_O) else $error("lock relay late");
  a_lock_arms: assert property ((acc && RF_MSG_I.cmd == CMD_LOCK &&
    !DOORS_I.any_open) |=> MODE_O == MODE_ARMED) else $error("no arm");
  a_unlock_relay: assert property (acc && RF_MSG_I.cmd == CMD_UNLOCK
    |-> ##[2:3] UNLOCK_RELAY_O) else $error("unlock relay late");
  a_unlock_len: assert property ($fell(UNLOCK_RELAY_O) |->
    relay_len >= 4 * TICK_DIV && relay_len <= 6 * TICK_DIV)
    else $error("unlock pulse length");
  a_unlock_disarm: assert property (acc && RF_MSG_I.cmd == CMD_UNLOCK
    |=> MODE_O != MODE_ARMED) else $error("still armed");
  a_refused_unlock: assert property ((RF_MSG_I.valid &&
    (KEY_IN_I || PAIRING_O) && RF_MSG_I.cmd == CMD_UNLOCK &&
    !UNLOCK_RELAY_O) |=> !UNLOCK_RELAY_O [*3]) else $error("acted");
  a_panic_horn: assert property ((acc && RF_MSG_I.cmd == CMD_PANIC &&
    !HORN_O) |-> ##[1:3] HORN_O) else $error("no panic horn");
  a_panic_stop: assert property ((acc && RF_MSG_I.cmd == CMD_UNLOCK &&
    HORN_O) |-> ##[1:3] !HORN_O) else $error("horn not stopped");
  a_lamp_on: assert property ((acc && RF_MSG_I.cmd == CMD_UNLOCK &&
    ROOM_LAMP_COUPLE_I) |-> ##[1:3] ROOM_LAMP_O) else $error("no lamp");
  a_fault_sticky: assert property ((!TESTER_CLEAR_I &&
    !$past(TESTER_CLEAR_I)) |=> (FAULTS_O & $past(FAULTS_O)) ==
    $past(FAULTS_O)) else $error("fault bit lost");
  c_lock: cover property (acc && RF_MSG_I.cmd == CMD_LOCK);
  c_unlock: cover property (acc && RF_MSG_I.cmd == CMD_UNLOCK && HORN_O);
  c_panic: cover property (acc && RF_MSG_I.cmd == CMD_PANIC);
endmodule : kea_controller_properties

bind kea_controller kea_controller_properties #(.TICK_DIV(TICK_DIV)) u_props (
  .CORE_CLK_I, .RST_I, .RF_MSG_I, .TESTER_SLOT_I, .TESTER_CLEAR_I, .KEY_IN_I,
  .DOORS_I, .ROOM_LAMP_COUPLE_I, .PAIRING_O, .MODE_O, .LOCK_RELAY_O,
  .UNLOCK_RELAY_O, .HORN_O, .ROOM_LAMP_O, .FAULTS_O);

// ===== verification/kea_controller_tb.sv
// Self-checking bench of the keyless entry controller
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  num_errors++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
  end end
module kea_controller_tb
  import kea_pkg::*;
;
  logic CORE_CLK_I = 1'h0, RST_I = 1'h1, BATT_RESTORE_I = 1'h0;
  logic TESTER_PAIR_I = 1'h0, TESTER_SLOT_I = 1'h0, TESTER_CLEAR_I = 1'h0;
  logic IGNITION_SWITCH_I = 1'h0, KEY_IN_I = 1'h0, ENGINE_RUN_I = 1'h0;
  logic ALTERNATOR_I = 1'h1, ROOM_LAMP_COUPLE_I = 1'h0, AUTO_LOCK_REQ_I = 1'h0;
  logic CENTRAL_SW_LOCK_I = 1'h0, DRIVER_SW_LOCK_I = 1'h0, PASS_SW_LOCK_I = 1'h0;
  logic CRASH_I = 1'h0, WASHER_SW_I = 1'h0, door_btn = 1'h0, panic_btn = 1'h0;
  logic [7:0] SPEED_I = 8'h00;
  logic [CODE_W-1:0] key_code = 32'h0;
  alarm_mode_t STORED_MODE_I = MODE_NORMAL;
  door_state_t DOORS_I = '0;
  rf_msg_t RF_MSG_I;
  alarm_mode_t MODE_O;
  logic PAIRING_O, LOCK_RELAY_O, UNLOCK_RELAY_O, HORN_O, HAZARD_O, ROOM_LAMP_O;
  logic [FLT_W-1:0] FAULTS_O;
  int num_errors = 0, n_checks = 0, hz_n = 0, lk_n = 0, hn_n = 0, i;
  logic hz_q = 1'h0, lk_q = 1'h0, hn_q = 1'h0;
  alarm_mode_t rs_m [5] = '{MODE_NORMAL, MODE_ARMED_READY, MODE_ARMED,
    MODE_WARNING, MODE_RELOCK_READY};
  alarm_mode_t rs_e [5] = '{MODE_NORMAL, MODE_NORMAL, MODE_ARMED,
    MODE_WARNING, MODE_NORMAL};

  always #12.5 CORE_CLK_I = ~CORE_CLK_I;
  // Rising edges of flashes, lock pulses and horn
  always @(posedge CORE_CLK_I) begin
    hz_n += int'(HAZARD_O & ~hz_q);
    lk_n += int'(LOCK_RELAY_O & ~lk_q);
    hn_n += int'(HORN_O & ~hn_q);
    {hz_q, lk_q, hn_q} <= {HAZARD_O, LOCK_RELAY_O, HORN_O};
  end

  kea_controller #(.TICK_DIV(4)) dut (.CORE_CLK_I, .RST_I, .BATT_RESTORE_I,
    .STORED_MODE_I, .MODE_O, .RF_MSG_I, .TESTER_PAIR_I, .TESTER_SLOT_I,
    .TESTER_CLEAR_I, .PAIRING_O, .IGNITION_SWITCH_I, .KEY_IN_I, .ENGINE_RUN_I,
    .ALTERNATOR_I, .SPEED_I, .DOORS_I, .ROOM_LAMP_COUPLE_I, .CENTRAL_SW_LOCK_I,
    .DRIVER_SW_LOCK_I, .PASS_SW_LOCK_I, .AUTO_LOCK_REQ_I, .CRASH_I,
    .WASHER_SW_I, .LOCK_RELAY_O, .UNLOCK_RELAY_O, .HORN_O, .HAZARD_O,
    .ROOM_LAMP_O, .FAULTS_O);
  kea_remote_model remote (.clk_i(CORE_CLK_I), .rst_i(RST_I),
    .door_btn_i(door_btn), .panic_btn_i(panic_btn), .code_i(key_code),
    .msg_o(RF_MSG_I));

  task automatic w(input int n);
    repeat (n) @(posedge CORE_CLK_I);
    #1;
  endtask : w
  // Press one remote button for len cycles, then let the frame land
  task automatic press(input logic p, input int len, input logic [31:0] c);
    @(posedge CORE_CLK_I);
    key_code <= c;
    door_btn <= !p;
    panic_btn <= p;
    repeat (len) @(posedge CORE_CLK_I);
    door_btn <= 1'h0;
    panic_btn <= 1'h0;
    w(5);
  endtask : press
  task automatic conclude();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    #(20000 * 25);
    num_errors++;
    conclude();
  end

  initial begin
    w(3);
    @(posedge CORE_CLK_I) RST_I <= 1'h0;
    w(1);
    press(1'h0, 10, 32'h1234abcd);
    `CHK("lock_unpaired", 1'h0, LOCK_RELAY_O)
    for (i = 0; i < KEY_SLOTS; i++) begin
      @(posedge CORE_CLK_I) TESTER_SLOT_I <= i[0];
      @(posedge CORE_CLK_I) TESTER_PAIR_I <= 1'h1;
      @(posedge CORE_CLK_I) TESTER_PAIR_I <= 1'h0;
      w(2);
      `CHK("pairing", 1'h1, PAIRING_O)
      press(1'h0, 10, 32'hc0de0000 + i);
      `CHK("pair_done", 1'h0, PAIRING_O)
      `CHK("pair_quiet", 1'h0, LOCK_RELAY_O)
    end
    hz_n = 0;
    press(1'h0, 10, 32'hc0de0000);
    `CHK("lock_relay", 1'h1, LOCK_RELAY_O)
    `CHK("mode_lock", MODE_ARMED, MODE_O)
    w(150);
    `CHK("lock_flash", 2, hz_n)
    `CHK("knob_lock", 1'h1, FAULTS_O[FLT_LOCK_OUT])
    @(posedge CORE_CLK_I) KEY_IN_I <= 1'h1;
    press(1'h0, 30, 32'hc0de0001);
    `CHK("unlock_key_in", 1'h0, UNLOCK_RELAY_O)
    `CHK("mode_key_in", MODE_ARMED, MODE_O)
    @(posedge CORE_CLK_I) {KEY_IN_I, ROOM_LAMP_COUPLE_I} <= 2'h1;
    @(posedge CORE_CLK_I) DOORS_I <= door_state_t'(3'h1);
    hz_n = 0;
    lk_n = 0;
    press(1'h0, 30, 32'hc0de0001);
    `CHK("unlock_relay", 1'h1, UNLOCK_RELAY_O)
    `CHK("room_lamp", 1'h1, ROOM_LAMP_O)
    `CHK("mode_unlock", 1'h1, MODE_O !== MODE_ARMED)
    w(100);
    `CHK("unlock_end", 1'h0, UNLOCK_RELAY_O)
    `CHK("unlock_flash", 1, hz_n)
    w(800);
    `CHK("lamp_held", 1'h1, ROOM_LAMP_O)
    w(500);
    `CHK("lamp_off", 1'h0, ROOM_LAMP_O)
    `CHK("relock_pulse", 1, lk_n)
    `CHK("relock_mode", MODE_ARMED, MODE_O)
    press(1'h1, 30, 32'hc0de0000);
    `CHK("panic_long", 1'h0, HORN_O)
    press(1'h1, 10, 32'hc0de0000);
    `CHK("panic_horn", 1'h1, HORN_O)
    w(990);
    `CHK("panic_held", 1'h1, HORN_O)
    w(200);
    `CHK("panic_end", 1'h0, HORN_O)
    press(1'h1, 10, 32'hc0de0001);
    @(posedge CORE_CLK_I) DOORS_I <= door_state_t'(3'h2);
    hz_n = 0;
    press(1'h0, 30, 32'hc0de0000);
    `CHK("panic_stop", 1'h0, HORN_O)
    w(150);
    `CHK("no_flash", 0, hz_n)
    `CHK("knob_unlock", 1'h1, FAULTS_O[FLT_UNLOCK_OUT])
    @(posedge CORE_CLK_I) TESTER_CLEAR_I <= 1'h1;
    @(posedge CORE_CLK_I) TESTER_CLEAR_I <= 1'h0;
    w(2);
    `CHK("clear", {FLT_W{1'h0}}, FAULTS_O)
    @(posedge CORE_CLK_I) {SPEED_I, CRASH_I, WASHER_SW_I} <= {8'hc9, 2'h3};
    w(450);
    `CHK("speed_max", 1'h1, FAULTS_O[FLT_SPEED_MAX])
    `CHK("crash", 1'h1, FAULTS_O[FLT_CRASH_IN])
    `CHK("washer", 1'h1, FAULTS_O[FLT_WASHER])
    @(posedge CORE_CLK_I) {SPEED_I, CRASH_I, WASHER_SW_I} <= {8'h04, 2'h0};
    @(posedge CORE_CLK_I) {IGNITION_SWITCH_I, ALTERNATOR_I} <= 2'h2;
    w(5);
    `CHK("speed_sig", 1'h1, FAULTS_O[FLT_SPEED_SIG])
    @(posedge CORE_CLK_I) {ALTERNATOR_I, SPEED_I} <= {1'h1, 8'h3c};
    @(posedge CORE_CLK_I) {AUTO_LOCK_REQ_I, DOORS_I} <= 4'h9;
    @(posedge CORE_CLK_I) AUTO_LOCK_REQ_I <= 1'h0;
    w(80);
    `CHK("auto_lock", 1'h1, FAULTS_O[FLT_AUTO_LOCK])
    @(posedge CORE_CLK_I) {ENGINE_RUN_I, SPEED_I} <= {1'h1, 8'h00};
    for (i = 0; i < 3; i++) begin
      @(posedge CORE_CLK_I) begin
        {CENTRAL_SW_LOCK_I, DRIVER_SW_LOCK_I, PASS_SW_LOCK_I} <= 3'h4 >> i;
      end
      w(4);
      `CHK("switch_lock", 1'h1, FAULTS_O[FLT_CENTRAL_SW + i])
      @(posedge CORE_CLK_I) PASS_SW_LOCK_I <= 1'h0;
    end
    // Ignition cycle must not touch the log
    @(posedge CORE_CLK_I) {IGNITION_SWITCH_I, ENGINE_RUN_I} <= 2'h0;
    w(4);
    @(posedge CORE_CLK_I) IGNITION_SWITCH_I <= 1'h1;
    w(4);
    `CHK("log_kept", 1'h1, FAULTS_O[FLT_SPEED_MAX])
    @(posedge CORE_CLK_I) IGNITION_SWITCH_I <= 1'h0;
    for (i = 0; i < 5; i++) begin
      @(posedge CORE_CLK_I) RST_I <= 1'h1;
      repeat (3) @(posedge CORE_CLK_I);
      {RST_I, STORED_MODE_I} <= {1'h0, rs_m[i]};
      @(posedge CORE_CLK_I) BATT_RESTORE_I <= 1'h1;
      hn_n = 0;
      w(3);
      `CHK("restore_mode", rs_e[i], MODE_O)
      w(40);
      if (i == 2) `CHK("restore_horn", 1'h1, hn_n > 0)
      @(posedge CORE_CLK_I) BATT_RESTORE_I <= 1'h0;
    end
    conclude();
  end
endmodule : kea_controller_tb
